// ===== shared/fstd_pkg.sv
// constants, encodings and carriers for the barrier and system-trap decoder.
// assumes a 32-bit instruction stream and an apb register slave on one clock.
//
// What this block does
// - successors unseen before all predecessor operations
// - order memory only, not interrupt-line observations
// - mode 0000 gives normal barrier
// - mode 1000 rw,rw gives store-order barrier
// - store-order barrier executed as full rw,rw
// - register fields of barrier ignored, producer zeroes
// - reserved barrier encodings run as normal barrier
// - conservative option orders every operation class
// - device-io addresses count as input/output classes
// - system opcode i-type decode, optional trap-all
// - service call raises precise requested trap
// - break call traps to debugging environment
// - semihost: entry shift, break, shift number 7
// - semihost shifts elsewhere are plain hints
// - hints only advance pc, nothing else
// - writes-only, empty successor barrier is pause
package fstd_pkg;

  // ---------------------------------------------------------------
  // instruction encodings
  // ---------------------------------------------------------------
  localparam logic [6:0] OPC_MISC_MEM = 7'h0F;
  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [6:0] OPC_OP_IMM = 7'h13;
  localparam logic [2:0] F3_BARRIER = 3'h0;
  localparam logic [2:0] F3_SHL = 3'h1;
  localparam logic [2:0] F3_SHR = 3'h5;
  localparam logic [11:0] IMM_ENV_CALL = 12'h000;
  localparam logic [11:0] IMM_DBG_BREAK = 12'h001;
  localparam logic [31:0] SEMI_ENTRY_WORD = 32'h01F0_1013;
  localparam logic [31:0] SEMI_BREAK_WORD = 32'h0010_0073;
  localparam logic [31:0] SEMI_EXIT_WORD = 32'h4070_5013;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_STORE_ORDER = 4'h8;
  // class bit positions inside a set: input, output, read, write
  localparam int CLS_IN = 3;
  localparam int CLS_OUT = 2;
  localparam int CLS_RD = 1;
  localparam int CLS_WR = 0;
  localparam logic [3:0] SET_RW = 4'h3;
  localparam logic [3:0] SET_W = 4'h1;
  localparam logic [3:0] SET_ALL = 4'hF;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVT = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam int CTRL_CONSERVATIVE = 0;
  localparam int CTRL_TRAP_ALL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int EVT_ENV = 0;
  localparam int EVT_BREAK = 1;
  localparam int EVT_SEMI = 2;
  localparam int EVT_PAUSE = 3;
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ---------------------------------------------------------------
  // trap causes (local encoding)
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CAUSE_NONE = 2'b00,
    CAUSE_ENV_CALL = 2'b01,
    CAUSE_DBG_BREAK = 2'b10,
    CAUSE_SYSTEM = 2'b11
  } fstd_cause_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DRAIN = 2'b01,
    ST_DONE = 2'b10
  } fstd_state_e;

  // one memory access event from the load/store path
  typedef struct packed {
    logic valid;
    logic store;
    logic dev_io;
  } fstd_acc_s;

  // barrier fields after decode
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] pred;
    logic [3:0] succ;
  } fstd_fence_s;

endpackage

// ===== rtl/fstd_outstanding.sv
// one outstanding-access counter for a single operation class.
// assumes issue and acknowledge pulses come from logic on the same clock.
`timescale 1ns/100ps

module fstd_outstanding
  import fstd_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic o_busy
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // ---------------------------------------------------------------
  // count
  // ---------------------------------------------------------------
  // saturating both ways so a stray ack cannot wrap to "busy forever"
  always_comb begin
    next_count = count;
    if (i_inc && !i_dec && count != {WIDTH{1'b1}}) begin
      next_count = count + WIDTH'(1);
    end else if (i_dec && !i_inc && count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count <= '0;
      o_busy <= 1'b0;
    end else begin
      count <= next_count;
      o_busy <= (next_count != '0);
    end
  end

endmodule

// ===== rtl/fstd_top.sv
// barrier and system-trap decoder with apb control and event interrupt.
// assumes the load/store path reports issue and ack of every access,
// and honours o_succ_block before issuing an access of a blocked class.
`timescale 1ns/100ps

module fstd_top
  import fstd_pkg::*;
#(
  parameter int CNT_WIDTH = 4
) (
  input wire logic i_clock,
  input wire logic i_rst,
  // instruction stream
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_instr_compressed,
  input wire logic [31:0] i_next_word,
  input wire logic i_next_compressed,
  output logic o_instr_ready,
  output logic o_retire,
  output logic o_hint,
  output logic o_pause,
  output logic o_trap,
  output fstd_cause_e o_trap_cause,
  output logic o_semihost,
  // memory access tracking
  input fstd_acc_s i_issue,
  input fstd_acc_s i_ack,
  output logic [3:0] o_succ_block,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // operation class of issue and ack events
  // ---------------------------------------------------------------
  logic [3:0] issue_cls;
  logic [3:0] ack_cls;
  logic [3:0] busy_cls;

  // io-region accesses count as input/output, not read/write
  always_comb begin
    issue_cls = 4'h0;
    ack_cls = 4'h0;
    issue_cls[CLS_IN] = i_issue.valid && i_issue.dev_io && !i_issue.store;
    issue_cls[CLS_OUT] = i_issue.valid && i_issue.dev_io && i_issue.store;
    issue_cls[CLS_RD] = i_issue.valid && !i_issue.dev_io && !i_issue.store;
    issue_cls[CLS_WR] = i_issue.valid && !i_issue.dev_io && i_issue.store;
    ack_cls[CLS_IN] = i_ack.valid && i_ack.dev_io && !i_ack.store;
    ack_cls[CLS_OUT] = i_ack.valid && i_ack.dev_io && i_ack.store;
    ack_cls[CLS_RD] = i_ack.valid && !i_ack.dev_io && !i_ack.store;
    ack_cls[CLS_WR] = i_ack.valid && !i_ack.dev_io && i_ack.store;
  end

  // one counter per class; only memory-system acks count as completion,
  // interrupt lines play no part in the ordering
  for (genvar g = 0; g < 4; g++) begin : g_cls
    fstd_outstanding #(
      .WIDTH(CNT_WIDTH)
    ) u_cnt (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_inc(issue_cls[g]),
      .i_dec(ack_cls[g]),
      .o_busy(busy_cls[g])
    );
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [1:0] ctrl;
  logic [3:0] evt;
  logic [3:0] mask;
  logic [1:0] next_ctrl;
  logic [3:0] next_evt;
  logic [3:0] next_mask;
  logic [3:0] evt_set;
  logic apb_access;
  logic apb_done;
  logic apb_hit;
  logic [31:0] next_prdata;

  assign apb_access = i_psel && i_penable && !o_pready;
  // writes land at the completing edge, the one where the master sees pready
  assign apb_done = i_psel && i_penable && o_pready;

  // address decode and read mux
  always_comb begin
    apb_hit = 1'b1;
    next_prdata = 32'h0000_0000;
    case (i_paddr)
      REG_CTRL: next_prdata = {30'h0, ctrl};
      REG_STATUS: next_prdata = {24'h0, busy_cls, o_succ_block};
      REG_EVT: next_prdata = {28'h0, evt};
      REG_MASK: next_prdata = {28'h0, mask};
      default: apb_hit = 1'b0;
    endcase
  end

  // write-one-to-clear events; a new event in the same cycle wins
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_evt = evt;
    if (apb_done && i_pwrite && i_paddr == REG_CTRL) begin
      next_ctrl = i_pwdata[1:0];
    end
    if (apb_done && i_pwrite && i_paddr == REG_MASK) begin
      next_mask = i_pwdata[3:0];
    end
    if (apb_done && i_pwrite && i_paddr == REG_EVT) begin
      next_evt = evt & ~i_pwdata[3:0];
    end
    next_evt = next_evt | evt_set;
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      evt <= EVT_RESET;
      mask <= MASK_RESET;
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      evt <= next_evt;
      mask <= next_mask;
      o_pready <= apb_access;
      o_prdata <= (apb_access && !i_pwrite && apb_hit) ? next_prdata : 32'h0000_0000;
      o_pslverr <= apb_access && !apb_hit;
      o_irq <= |(next_evt & next_mask);
    end
  end

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  logic [6:0] opc;
  logic [2:0] f3;
  logic [4:0] rd_idx;
  logic [4:0] rs_idx;
  logic is_fence;
  logic is_system;
  logic is_env;
  logic is_break;
  logic is_shift_hint;
  logic is_pause;
  logic semi_match;
  fstd_fence_s fence_raw;
  fstd_fence_s fence_eff;
  logic take;

  assign take = i_instr_valid && o_instr_ready;
  assign opc = i_instr[6:0];
  assign f3 = i_instr[14:12];
  assign rd_idx = i_instr[11:7];
  assign rs_idx = i_instr[19:15];

  // register fields of a barrier are read only by the pause decode below
  assign fence_raw = '{mode: i_instr[31:28], pred: i_instr[27:24], succ: i_instr[23:20]};

  always_comb begin
    is_fence = !i_instr_compressed && opc == OPC_MISC_MEM && f3 == F3_BARRIER;
    // i-type layout: funct12 in the top bits, no register write
    is_system = !i_instr_compressed && opc == OPC_SYSTEM;
    is_env = is_system && f3 == 3'h0 && i_instr[31:20] == IMM_ENV_CALL && rd_idx == 5'h0 && rs_idx == 5'h0;
    is_break = is_system && f3 == 3'h0 && i_instr[31:20] == IMM_DBG_BREAK && rd_idx == 5'h0 && rs_idx == 5'h0;
    // shifts writing the zero register only advance the pc
    is_shift_hint = opc == OPC_OP_IMM && rd_idx == 5'h0 && (f3 == F3_SHL || f3 == F3_SHR);
    // pause code point: zero regs, mode 0, pred=w, succ empty
    is_pause = is_fence && rd_idx == 5'h0 && rs_idx == 5'h0 && fence_raw.mode == MODE_NORMAL
               && fence_raw.pred == SET_W && fence_raw.succ == 4'h0;
  end

  // effective ordering sets of the barrier
  always_comb begin
    fence_eff = fence_raw;
    // normal barrier uses sets as given
    if (fence_raw.mode == MODE_STORE_ORDER && fence_raw.pred == SET_RW && fence_raw.succ == SET_RW) begin
      // store-order relaxation dropped: full rw,rw is a superset
      fence_eff.mode = MODE_NORMAL;
    end else begin
      // every other mode runs as a normal barrier on the given sets
      fence_eff.mode = MODE_NORMAL;
    end
    if (ctrl[CTRL_CONSERVATIVE]) begin
      fence_eff.pred = SET_ALL;
      fence_eff.succ = SET_ALL;
    end
  end

  // semihost: entry shift before, exit shift after, all full width
  logic [31:0] prev_word;
  logic prev_full;
  logic [31:0] next_prev_word;
  logic next_prev_full;

  assign semi_match = is_break && prev_full && prev_word == SEMI_ENTRY_WORD && !i_next_compressed
                      && i_next_word == SEMI_EXIT_WORD && i_instr == SEMI_BREAK_WORD;

  always_comb begin
    next_prev_word = prev_word;
    next_prev_full = prev_full;
    if (take) begin
      next_prev_word = i_instr;
      next_prev_full = !i_instr_compressed;
    end
  end

  // ---------------------------------------------------------------
  // execution state machine
  // ---------------------------------------------------------------
  fstd_state_e state;
  fstd_state_e next_state;
  logic [3:0] pred_held;
  logic [3:0] next_pred_held;
  logic [3:0] next_block;
  logic next_retire;
  logic next_hint;
  logic next_pause;
  logic next_trap;
  fstd_cause_e next_cause;
  logic next_semihost;

  always_comb begin
    next_state = state;
    next_pred_held = pred_held;
    next_block = o_succ_block;
    next_retire = 1'b0;
    next_hint = 1'b0;
    next_pause = 1'b0;
    next_trap = 1'b0;
    next_cause = CAUSE_NONE;
    next_semihost = 1'b0;
    evt_set = 4'h0;
    case (state)
      ST_IDLE: begin
        if (take) begin
          if (is_system && ctrl[CTRL_TRAP_ALL]) begin
            next_trap = 1'b1; // single handler for all system ops
            next_cause = CAUSE_SYSTEM;
            next_state = ST_DONE;
          end else if (is_env) begin
            next_trap = 1'b1; // precise requested trap
            next_cause = CAUSE_ENV_CALL;
            evt_set[EVT_ENV] = 1'b1;
            next_state = ST_DONE;
          end else if (is_break) begin
            next_trap = 1'b1; // hand control to debugger
            next_cause = CAUSE_DBG_BREAK;
            next_semihost = semi_match;
            evt_set[EVT_BREAK] = 1'b1;
            evt_set[EVT_SEMI] = semi_match;
            next_state = ST_DONE;
          end else if (is_system) begin
            next_trap = 1'b1; // unhandled system op goes to software
            next_cause = CAUSE_SYSTEM;
            next_state = ST_DONE;
          end else if (is_fence) begin
            // block successors, wait for predecessors
            next_pred_held = fence_eff.pred;
            next_block = fence_eff.succ;
            next_pause = is_pause;
            evt_set[EVT_PAUSE] = is_pause;
            next_state = ST_DRAIN;
          end else begin
            next_retire = 1'b1;
            next_hint = is_shift_hint;
            next_state = ST_DONE;
          end
        end
      end
      ST_DRAIN: begin
        if ((busy_cls & pred_held) == 4'h0) begin
          next_block = 4'h0;
          next_pred_held = 4'h0;
          next_retire = 1'b1;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ready is low while draining and in the cycle that shows each result
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_IDLE;
      pred_held <= 4'h0;
      prev_word <= 32'h0000_0000;
      prev_full <= 1'b0;
      o_instr_ready <= 1'b0;
      o_succ_block <= 4'h0;
      o_retire <= 1'b0;
      o_hint <= 1'b0;
      o_pause <= 1'b0;
      o_trap <= 1'b0;
      o_trap_cause <= CAUSE_NONE;
      o_semihost <= 1'b0;
    end else begin
      state <= next_state;
      pred_held <= next_pred_held;
      prev_word <= next_prev_word;
      prev_full <= next_prev_full;
      o_instr_ready <= (next_state == ST_IDLE);
      o_succ_block <= next_block;
      o_retire <= next_retire;
      o_hint <= next_hint;
      o_pause <= next_pause;
      o_trap <= next_trap;
      o_trap_cause <= next_cause;
      o_semihost <= next_semihost;
    end
  end

endmodule

// ===== dv/fstd_checker.sv
// concurrent checks on the ports of the barrier and system-trap decoder.
// assumes it is bound onto fstd_top and sees nothing but its ports.
`timescale 1ns/100ps

module fstd_checker
  import fstd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_instr_compressed,
  input wire logic o_instr_ready,
  input wire logic o_retire,
  input wire logic o_hint,
  input wire logic o_pause,
  input wire logic o_trap,
  input fstd_cause_e o_trap_cause,
  input wire logic o_semihost,
  input wire logic [3:0] o_succ_block,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // a full-width word accepted at this edge
  sequence s_take(logic [31:0] w);
    i_instr_valid && o_instr_ready && !i_instr_compressed && i_instr == w;
  endsequence
  // barrier hold released
  sequence s_blk_drop;
    (o_succ_block != 4'h0) ##1 (o_succ_block == 4'h0);
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // trap-all mode may turn both calls into cause 11
  property p_env;
    s_take(32'h0000_0073) |=> o_trap && o_trap_cause inside {CAUSE_ENV_CALL, CAUSE_SYSTEM};
  endproperty
  a_env: assert property (p_env) else $error("service call did not trap");
  property p_brk;
    s_take(SEMI_BREAK_WORD) |=> o_trap && o_trap_cause inside {CAUSE_DBG_BREAK, CAUSE_SYSTEM};
  endproperty
  a_brk: assert property (p_brk) else $error("break call did not trap");
  property p_semi;
    o_semihost |-> o_trap && o_trap_cause == CAUSE_DBG_BREAK;
  endproperty
  a_semi: assert property (p_semi) else $error("semihost without break trap");
  property p_hint;
    o_hint |-> o_retire && !o_trap && o_succ_block == 4'h0;
  endproperty
  a_hint: assert property (p_hint) else $error("hint had a visible effect");
  property p_pause;
    s_take(32'h0100_000F) |=> o_pause;
  endproperty
  a_pause: assert property (p_pause) else $error("pause code point missed");
  property p_blk;
    s_take(32'h0330_000F) |=> o_succ_block[1:0] == 2'b11 && !o_retire;
  endproperty
  a_blk: assert property (p_blk) else $error("rw barrier did not hold successors");
  property p_clr;
    s_blk_drop |-> o_retire;
  endproperty
  a_clr: assert property (p_clr) else $error("hold dropped without retire");
  property p_rdy;
    i_instr_valid && o_instr_ready |=> !o_instr_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready stayed high after take");
  // one wait state, answer stands one cycle
  property p_apb;
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");
endmodule

// ===== dv/fstd_mem_model.sv
// load/store path and memory model: one outstanding access at a time.
// assumes the bench pulses i_go for one cycle; i_delay is at least 1.
`timescale 1ns/100ps

module fstd_mem_model
  import fstd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_store,
  input wire logic i_dev,
  input wire logic [3:0] i_delay,
  input wire logic [3:0] i_block,
  output fstd_acc_s o_issue,
  output fstd_acc_s o_ack
);
  logic pend;
  logic st;
  logic dv;
  logic [3:0] cnt;
  logic [3:0] cls;

  // device-io addresses map to the input/output classes
  assign cls = dv ? (st ? 4'h4 : 4'h8) : (st ? 4'h1 : 4'h2);

  // ---------------------------------------------------------------
  // issue and acknowledge
  // ---------------------------------------------------------------
  // a blocked class waits; issuing it anyway would hide ordering bugs
  always @(posedge i_clock) begin
    o_issue <= '0;
    o_ack <= '0;
    if (i_rst) begin
      pend <= 1'b0;
      cnt <= 4'h0;
    end else begin
      if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (cnt == 4'h1) o_ack <= '{1'b1, st, dv};
      if (i_go) begin
        pend <= 1'b1;
        st <= i_store;
        dv <= i_dev;
      end else if (pend && (cls & i_block) == 4'h0) begin
        pend <= 1'b0;
        o_issue <= '{1'b1, st, dv};
        cnt <= i_delay;
      end
    end
  end
endmodule

// ===== dv/fstd_top_tb.sv
// self-checking bench for the barrier and system-trap decoder.
// assumes fstd_top, fstd_mem_model and fstd_checker are compiled first.
`timescale 1ns/100ps

module fstd_top_tb
  import fstd_pkg::*;
;
  logic i_clock = 0, i_rst = 1, i_instr_valid = 0, i_next_compressed = 0, i_instr_compressed = 0;
  logic [31:0] i_instr = 0, i_next_word = 0, i_pwdata = 0;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0, go = 0, st = 0, dv = 0;
  logic [7:0] i_paddr = 0;
  logic [3:0] dly = 4'h1;
  logic o_instr_ready, o_retire, o_hint, o_pause, o_trap, o_semihost, o_pready, o_pslverr, o_irq;
  fstd_cause_e o_trap_cause;
  logic [3:0] o_succ_block;
  logic [31:0] o_prdata, d;
  fstd_acc_s iss, ack;
  logic r_ret, r_hint, r_pause, r_trap, r_semi, e;
  logic [1:0] r_cause;
  logic [3:0] r_blk;
  int bad_count = 0, num_checks = 0, ack_cnt = 0, r_acks, a0;

  initial forever #25 i_clock = ~i_clock;
  always @(posedge i_clock) if (ack.valid === 1'b1) ack_cnt <= ack_cnt + 1;

  fstd_top u_fstd_top (.i_clock(i_clock), .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_instr_compressed(i_instr_compressed), .i_next_word(i_next_word), .i_next_compressed(i_next_compressed),
    .o_instr_ready(o_instr_ready), .o_retire(o_retire), .o_hint(o_hint), .o_pause(o_pause), .o_trap(o_trap),
    .o_trap_cause(o_trap_cause), .o_semihost(o_semihost), .i_issue(iss), .i_ack(ack),
    .o_succ_block(o_succ_block), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_irq(o_irq));
  fstd_mem_model u_fstd_mem_model (.i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_store(st), .i_dev(dv),
    .i_delay(dly), .i_block(o_succ_block), .o_issue(iss), .o_ack(ack));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask
  // apb master: setup, access, hold until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin @(posedge i_clock); n++; end while (o_pready !== 1'b1 && n < 20);
    d = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) hang();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(d, x);
    chk(e, 1'b0);
  endtask
  task automatic irqchk(input logic x);
    @(posedge i_clock);
    #1 chk(o_irq, x);
  endtask
  // offer one word, gather every result pulse until retire or trap
  task automatic do_instr(input logic [31:0] w, input logic [31:0] nw, input logic nc);
    int n;
    {r_ret, r_hint, r_pause, r_trap, r_semi, r_cause, r_blk} = '0;
    @(posedge i_clock);
    i_instr_valid <= 1'b1; i_instr <= w; i_next_word <= nw; i_next_compressed <= nc;
    n = 0;
    do begin @(posedge i_clock); n++; end while (o_instr_ready !== 1'b1 && n < 40);
    i_instr_valid <= 1'b0;
    // sample just after each edge, starting at the take edge, so one-cycle pulses are seen
    while (r_ret !== 1'b1 && r_trap !== 1'b1 && n < 80) begin
      #1 n++;
      {r_ret, r_trap, r_cause} = {o_retire, o_trap, o_trap_cause};
      {r_hint, r_pause, r_semi} = {r_hint | o_hint, r_pause | o_pause, r_semi | o_semihost};
      r_blk = r_blk | o_succ_block;
      r_acks = ack_cnt;
      @(posedge i_clock);
    end
    if (n >= 80) hang();
  endtask
  task automatic mem_go(input logic s, input logic v);
    @(posedge i_clock);
    go <= 1'b1; st <= s; dv <= v; dly <= 4'h8;
    @(posedge i_clock);
    go <= 1'b0;
    a0 = ack_cnt;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rdchk(REG_CTRL, 32'h0); rdchk(REG_EVT, 32'h0); rdchk(REG_MASK, 32'h0); rdchk(REG_STATUS, 32'h0);
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    rdchk(REG_STATUS, 32'h0);
    apb(1'b1, 8'h10, 32'h1); // unmapped place is refused
    chk(e, 1'b1);
    chk(d, 32'h0);
  endtask
  task automatic t_irq;
    do_instr(32'h0000_0073, 32'h0, 1'b0);
    chk(r_cause, CAUSE_ENV_CALL);
    rdchk(REG_EVT, 32'h1); irqchk(1'b0);
    apb(1'b1, REG_MASK, 32'h1); irqchk(1'b1);
    apb(1'b1, REG_EVT, 32'h1); irqchk(1'b0);
    rdchk(REG_EVT, 32'h0);
    apb(1'b1, REG_MASK, 32'h0);
  endtask
  task automatic t_sys;
    do_instr(SEMI_BREAK_WORD, 32'h0, 1'b0);
    chk({r_trap, r_cause, r_semi}, {1'b1, CAUSE_DBG_BREAK, 1'b0});
    do_instr(32'h0000_00F3, 32'h0, 1'b0);
    chk({r_trap, r_cause}, {1'b1, CAUSE_SYSTEM});
    do_instr(SEMI_ENTRY_WORD, 32'h0, 1'b0);
    chk({r_ret, r_hint, r_trap}, 3'b110);
    do_instr(SEMI_BREAK_WORD, SEMI_EXIT_WORD, 1'b0);
    chk({r_trap, r_cause, r_semi}, {1'b1, CAUSE_DBG_BREAK, 1'b1});
    do_instr(SEMI_ENTRY_WORD, 32'h0, 1'b0);
    do_instr(SEMI_BREAK_WORD, SEMI_EXIT_WORD, 1'b1);
    chk(r_semi, 1'b0);
    // a compressed entry word must not arm the sequence
    i_instr_compressed <= 1'b1;
    do_instr(SEMI_ENTRY_WORD, 32'h0, 1'b0);
    i_instr_compressed <= 1'b0;
    do_instr(SEMI_BREAK_WORD, SEMI_EXIT_WORD, 1'b0);
    chk({r_trap, r_semi}, 2'b10);
    do_instr(SEMI_EXIT_WORD, 32'h0, 1'b0);
    chk({r_ret, r_hint}, 2'b11);
    rdchk(REG_EVT, 32'h6);
    apb(1'b1, REG_EVT, 32'hF);
  endtask
  task automatic t_fence;
    logic [31:0] fw [5] = '{32'h0330_000F, 32'h8330_000F, 32'h4840_000F, 32'h0330_808F, 32'h0100_000F};
    logic [3:0] fb [5] = '{4'h3, 4'h3, 4'h4, 4'h3, 4'h0};
    for (int i = 0; i < 5; i++) begin
      do_instr(fw[i], 32'h0, 1'b0);
      chk({r_ret, r_blk, r_pause}, {1'b1, fb[i], i == 4});
    end
    rdchk(REG_EVT, 32'h8);
    mem_go(1'b0, 1'b0);
    do_instr(32'h0330_000F, 32'h0, 1'b0);
    chk(r_acks - a0, 32'h1);
    mem_go(1'b0, 1'b1);
    do_instr(32'h0820_000F, 32'h0, 1'b0);
    chk(r_blk, 4'h2);
    chk(r_acks - a0, 32'h1);
  endtask
  task automatic t_cons;
    apb(1'b1, REG_CTRL, 32'h1);
    rdchk(REG_CTRL, 32'h1);
    do_instr(32'h0120_000F, 32'h0, 1'b0);
    chk(r_blk, 4'hF);
    apb(1'b1, REG_CTRL, 32'h2);
    do_instr(32'h0000_0073, 32'h0, 1'b0);
    chk(r_cause, CAUSE_SYSTEM);
    apb(1'b1, REG_CTRL, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_irq();
    t_sys();
    t_fence();
    t_cons();
    test_done();
  end
endmodule

bind fstd_top fstd_checker u_fstd_checker (.i_clock(i_clock), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
  .i_instr(i_instr), .i_instr_compressed(i_instr_compressed), .o_instr_ready(o_instr_ready),
  .o_retire(o_retire), .o_hint(o_hint), .o_pause(o_pause), .o_trap(o_trap), .o_trap_cause(o_trap_cause),
  .o_semihost(o_semihost), .o_succ_block(o_succ_block), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready));
